// file: dv/c16bj_regfile_model.sv
/*
  register file seen by the decoder: combinational read on the indexed port
  and a fixed port on the stack register, writes from both write-back carriers.
  assumes the bench may preload any register between clock edges.
*/
`timescale 1ns/1ps
`include "c16bj_map.svh"
module c16bj_regfile_model (
  // clock
  input wire logic clock,
  // read side
  input wire logic [4:0] srcRegIdx,
  output logic [31:0] srcRegData,
  output logic [31:0] stackRegData,
  // write side
  input wire c16bj_pkg::c16bj_wb_s wbOut,
  input wire c16bj_pkg::c16bj_wb_s stackWbOut
);
  // ==========================================
  // storage
  logic [31:0] regs [32]; // general registers
  // reads settle in the issue cycle
  assign srcRegData = regs[srcRegIdx];
  assign stackRegData = regs[`C16BJ_REG_STACK];
  // link and stack writes land on the edge after the pulse
  always @(posedge clock)
  begin
    if (wbOut.en)
      regs[wbOut.addr] <= wbOut.data;
    if (stackWbOut.en)
      regs[stackWbOut.addr] <= stackWbOut.data;
  end
endmodule

// file: dv/test_c16bj_decode.sv
/*
  self-checking bench: random compact branch, break and jump words issued in all but random idle
  every cycle, compared against a bench model at every result.
  assumes the register file model in dv and the decoder files in hdl.
*/
`timescale 1ns/1ps
`include "c16bj_map.svh"
module test_c16bj_decode;
  // ==========================================
  // signals
  logic clock, rst, issueValid, brkExcOut, irqHoldOut, eBrk, eIrq, skip;
  logic [15:0] instrWord;
  logic [31:0] instrPc, srcRegData, stackRegData, val, rnd;
  logic [4:0] srcRegIdx, eIdx;
  c16bj_pkg::c16bj_redir_s redirOut, redirW, eRed, eRedW;
  c16bj_pkg::c16bj_wb_s wbOut, stackWbOut, eWb, eSt;
  int n_mismatch = 0;
  int comparisons = 0;
  int seed = 32'h6c35;
  int kind; // 0 beqz 1 bnez 2 break 3 jalr 4 jr 5 jrsp 6 other 7 idle
  // ==========================================
  // instances: single-set core, dual-set core for alignment errors
  c16bj_decode #(.HAS_WORD_ISA(1'b0)) dut_u (.clock(clock), .rst(rst),
    .issueValid(issueValid), .instrWord(instrWord), .instrPc(instrPc),
    .srcRegIdx(srcRegIdx), .srcRegData(srcRegData), .stackRegData(stackRegData),
    .redirOut(redirOut), .wbOut(wbOut), .stackWbOut(stackWbOut),
    .brkExcOut(brkExcOut), .irqHoldOut(irqHoldOut));
  c16bj_decode #(.HAS_WORD_ISA(1'b1)) dut_w (.clock(clock), .rst(rst),
    .issueValid(issueValid), .instrWord(instrWord), .instrPc(instrPc),
    .srcRegIdx(), .srcRegData(srcRegData), .stackRegData(stackRegData),
    .redirOut(redirW), .wbOut(), .stackWbOut(), .brkExcOut(), .irqHoldOut());
  c16bj_regfile_model part_u (.clock(clock), .srcRegIdx(srcRegIdx),
    .srcRegData(srcRegData), .stackRegData(stackRegData), .wbOut(wbOut),
    .stackWbOut(stackWbOut));
  // ==========================================
  // checking
  task chk(input string nm, input logic [37:0] seen, input logic [37:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // every registered output against the model, one cycle after issue
  task cmp;
    chk("redirOut", redirOut, eRed);
    chk("redirWord", redirW, eRedW);
    chk("wbOut", wbOut, eWb);
    chk("stackWbOut", stackWbOut, eSt);
    chk("brkExcOut", brkExcOut, eBrk);
    chk("irqHoldOut", irqHoldOut, eIrq);
  endtask
  task test_done;
    if (n_mismatch == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================
  // one cycle: check last results, issue a new word, predict its results
  task step;
    @(posedge clock);
    #1;
    cmp();
    // the word after a transfer is dropped, no delay slot
    skip = eRed.valid | eBrk;
    kind = {$random(seed)} % 8;
    rnd = $random(seed);
    instrPc = $random(seed) & 32'hFFFF_FFFE;
    case (kind)
      0: instrWord = {`C16BJ_MAJ_BEQZ, rnd[9:0]};
      1: instrWord = {`C16BJ_MAJ_BNEZ, rnd[9:0]};
      2: instrWord = {`C16BJ_MAJ_POOLC, rnd[3:0], `C16BJ_MIN_BREAK};
      3: instrWord = {`C16BJ_MAJ_POOLC, rnd[4:0], `C16BJ_MIN_JALR};
      4: instrWord = {`C16BJ_MAJ_POOLC, rnd[4:0], `C16BJ_MIN_JR};
      5: instrWord = {`C16BJ_MAJ_POOLC, rnd[4:0], `C16BJ_MIN_JRSP};
      // unused pool minor or foreign major: must decode to nothing
      6: instrWord = rnd[15] ? {6'h01, rnd[9:0]} : {`C16BJ_MAJ_POOLC, rnd[4:0], 5'h1F};
      // a real jump word with no issue: must be ignored
      default: instrWord = {`C16BJ_MAJ_POOLC, rnd[4:0], `C16BJ_MIN_JR};
    endcase
    issueValid = (kind != 7);
    // short codes 0 and 1 reach registers 16 and 17
    case (kind)
      0, 1: eIdx = (instrWord[9:7] < 3'h2) ? 5'h10 + instrWord[9:7] : {2'h0, instrWord[9:7]};
      3, 4, 7: eIdx = instrWord[9:5];
      5: eIdx = `C16BJ_REG_LINK;
      default: eIdx = 5'h00;
    endcase
    // half the sources zero so both branch outcomes and mode bits occur
    part_u.regs[29] = $random(seed);
    part_u.regs[eIdx] = rnd[31] ? 32'h0000_0000 : $random(seed);
    #1;
    chk("srcRegIdx", srcRegIdx, eIdx);
    val = part_u.regs[eIdx];
    eRed = '0;
    eWb = '0;
    eSt = '0;
    eBrk = 1'b0;
    eIrq = 1'b0;
    if (issueValid && !skip)
      case (kind)
        0, 1:
          if ((val == 32'h0) == (kind == 0))
          begin
            eRed.valid = 1'b1;
            eRed.target = instrPc + 32'h2 + {{24{instrWord[6]}}, instrWord[6:0], 1'b0};
            eRed.modeBit = 1'b1;
          end
        2: eBrk = 1'b1;
        3, 4, 5:
        begin
          eRed.valid = 1'b1;
          eRed.target = {val[31:1], 1'b0};
          eRed.modeBit = val[0];
          eRed.addrErr = ~val[0];
          if (kind == 3)
            eWb = {1'b1, 5'h1F, instrPc + 32'h2};
          if (kind == 5)
          begin
            eSt = {1'b1, 5'h1D, part_u.regs[29] + {25'h0, instrWord[9:5], 2'h0}};
            eIrq = 1'b1;
          end
        end
        default: ;
      endcase
    eRedW = eRed;
    if (eRed.valid && kind > 2)
      eRedW.addrErr = ~val[0] & val[1];
  endtask
  // ==========================================
  // clock
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // ==========================================
  // main sequence
  initial
  begin
    rst = 1'b1;
    issueValid = 1'b0;
    instrWord = 16'h0000;
    instrPc = 32'h0000_0000;
    eRed = '0;
    eRedW = '0;
    eWb = '0;
    eSt = '0;
    eBrk = 1'b0;
    eIrq = 1'b0;
    for (int i = 0; i < 32; i++)
      part_u.regs[i] = 32'h0000_0000;
    // outputs stay cleared throughout reset
    repeat (6)
    begin
      @(posedge clock);
      #1;
      cmp();
    end
    rst = 1'b0;
    repeat (4000)
      step();
    @(posedge clock);
    #1;
    cmp();
    test_done();
  end
endmodule

// file: hdl/c16bj_decode.sv
/*
  decode and execute of the 16-bit compact branch, breakpoint and register
  jump group. assumes a combinational register file read in the issue cycle
  (one port addressed by srcRegIdx, one fixed on the stack register) and a
  fetch unit that follows redirOut at once.
*/
`timescale 1ns/1ps
module c16bj_decode #(
  parameter bit HAS_WORD_ISA = 1'b0 // core implements both instruction sets
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // issue from fetch
  input wire logic issueValid,
  input wire logic [15:0] instrWord,
  input wire logic [31:0] instrPc,
  // register file read
  output logic [4:0] srcRegIdx,
  input wire logic [31:0] srcRegData,
  input wire logic [31:0] stackRegData,
  // results
  output c16bj_pkg::c16bj_redir_s redirOut,
  output c16bj_pkg::c16bj_wb_s wbOut,
  output c16bj_pkg::c16bj_wb_s stackWbOut,
  output logic brkExcOut,
  output logic irqHoldOut
);
`include "c16bj_map.svh"

  // ==========================================
  // decode
  c16bj_pkg::c16bj_op_e opSel; // operation of the issued word
  logic [5:0] majorOp;         // bits 15..10
  logic [2:0] shortSrc;        // 3-bit register code
  logic issueOk;               // issue accepted this cycle
  logic [31:0] branchTarget;   // pc+2 plus scaled offset
  logic [31:0] linkValue;      // return address
  logic [31:0] jumpTarget;
  logic jumpMode;
  logic jumpErr;
  logic takeBranch;            // conditional branch resolves taken

  assign majorOp = instrWord[15:`C16BJ_MAJ_LSB];
  assign shortSrc = instrWord[`C16BJ_SRC3_LSB +: 3];

  // major opcode first, then the pool minors; break has the widest minor
  always_comb
  begin
    opSel = c16bj_pkg::OP_NONE;
    if (majorOp == `C16BJ_MAJ_BEQZ)
    begin
      opSel = c16bj_pkg::OP_BEQZ;
    end
    else if (majorOp == `C16BJ_MAJ_BNEZ)
    begin
      opSel = c16bj_pkg::OP_BNEZ;
    end
    else if (majorOp == `C16BJ_MAJ_POOLC)
    begin
      if (instrWord[5:0] == `C16BJ_MIN_BREAK)
      begin
        opSel = c16bj_pkg::OP_BREAK;
      end
      else if (instrWord[4:0] == `C16BJ_MIN_JALR)
      begin
        opSel = c16bj_pkg::OP_JALR;
      end
      else if (instrWord[4:0] == `C16BJ_MIN_JR)
      begin
        opSel = c16bj_pkg::OP_JR;
      end
      else if (instrWord[4:0] == `C16BJ_MIN_JRSP)
      begin
        opSel = c16bj_pkg::OP_JRSP;
      end
    end
  end

  // ==========================================
  // register read selection
  // short codes reach only eight registers; 0 and 1 stand for 16 and 17
  always_comb
  begin
    srcRegIdx = 5'h00;
    case (opSel)
      c16bj_pkg::OP_BEQZ, c16bj_pkg::OP_BNEZ:
      begin
        if (shortSrc == 3'h0)
        begin
          srcRegIdx = `C16BJ_REG_LOW0;
        end
        else if (shortSrc == 3'h1)
        begin
          srcRegIdx = `C16BJ_REG_LOW1;
        end
        else
        begin
          srcRegIdx = {2'h0, shortSrc};
        end
      end
      c16bj_pkg::OP_JALR, c16bj_pkg::OP_JR:
      begin
        srcRegIdx = instrWord[`C16BJ_SRC5_LSB +: 5]; // any register
      end
      c16bj_pkg::OP_JRSP:
      begin
        srcRegIdx = `C16BJ_REG_LINK;
      end
      default:
      begin
        srcRegIdx = 5'h00;
      end
    endcase
  end

  // ==========================================
  // address arithmetic
  // offset is relative to the following instruction, not the branch
  assign linkValue = instrPc + `C16BJ_PC_STEP;
  assign branchTarget = linkValue
    + {{24{instrWord[`C16BJ_OFF_MSB]}}, instrWord[`C16BJ_OFF_MSB:0], 1'b0};

  // zero test on the selected register decides the condition
  always_comb
  begin
    if (opSel == c16bj_pkg::OP_BEQZ)
    begin
      takeBranch = (srcRegData == `C16BJ_RST_WORD);
    end
    else if (opSel == c16bj_pkg::OP_BNEZ)
    begin
      takeBranch = (srcRegData != `C16BJ_RST_WORD);
    end
    else
    begin
      takeBranch = 1'b0;
    end
  end

  // bit 0 mode and alignment handling shared by all register jumps
  c16bj_jump_target #(
    .HAS_WORD_ISA(HAS_WORD_ISA)
  ) uTarget (
    .srcValue(srcRegData),
    .target(jumpTarget),
    .modeBit(jumpMode),
    .addrErr(jumpErr)
  );

  // ==========================================
  // issue acceptance
  // the word issued while a redirect or trap is out is the one right after
  // a control transfer; it is dropped, so no delay slot ever executes.
  // any instruction, transfers included, is accepted in every other cycle.
  assign issueOk = issueValid && !redirOut.valid && !brkExcOut;

  // ==========================================
  // fetch redirect
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      redirOut <= '0;
    end
    else
    begin
      redirOut <= '0;
      if (issueOk && takeBranch)
      begin
        // compact code stays in compact mode on a branch
        redirOut.valid <= 1'b1;
        redirOut.target <= branchTarget;
        redirOut.modeBit <= 1'b1;
        redirOut.addrErr <= 1'b0;
      end
      else if (issueOk && (opSel == c16bj_pkg::OP_JALR || opSel == c16bj_pkg::OP_JR
               || opSel == c16bj_pkg::OP_JRSP))
      begin
        redirOut.valid <= 1'b1;
        redirOut.target <= jumpTarget;
        redirOut.modeBit <= jumpMode;
        redirOut.addrErr <= jumpErr;
      end
    end
  end

  // ==========================================
  // link write-back
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wbOut <= '0;
    end
    else
    begin
      wbOut <= '0;
      if (issueOk && opSel == c16bj_pkg::OP_JALR)
      begin
        wbOut.en <= 1'b1;
        wbOut.addr <= `C16BJ_REG_LINK;
        wbOut.data <= linkValue;
      end
    end
  end

  // ==========================================
  // stack adjust write-back
  // plain 32-bit add: carry out is discarded and nothing traps
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      stackWbOut <= '0;
    end
    else
    begin
      stackWbOut <= '0;
      if (issueOk && opSel == c16bj_pkg::OP_JRSP)
      begin
        stackWbOut.en <= 1'b1;
        stackWbOut.addr <= `C16BJ_REG_STACK;
        stackWbOut.data <= stackRegData
          + {25'h0, instrWord[`C16BJ_SRC5_LSB +: 5], 2'h0};
      end
    end
  end

  // ==========================================
  // breakpoint trap
  // only the trap pulse leaves; the code field goes nowhere, the handler
  // must reread the instruction word from memory
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      brkExcOut <= 1'b0;
    end
    else
    begin
      brkExcOut <= issueOk && opSel == c16bj_pkg::OP_BREAK;
    end
  end

  // ==========================================
  // interrupt hold-off
  // jump and stack update retire in one cycle; the hold pulse keeps an
  // interrupt from being taken between them
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      irqHoldOut <= 1'b0;
    end
    else
    begin
      irqHoldOut <= issueOk && opSel == c16bj_pkg::OP_JRSP;
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  beqz_take_a: assert property (issueOk && opSel == c16bj_pkg::OP_BEQZ
    |=> redirOut.valid == ($past(srcRegData) == 32'h0000_0000))
    else $error("zero branch decision wrong");
  bnez_take_a: assert property (issueOk && opSel == c16bj_pkg::OP_BNEZ
    |=> redirOut.valid == ($past(srcRegData) != 32'h0000_0000))
    else $error("nonzero branch decision wrong");
  branch_target_a: assert property (issueOk && takeBranch
    |=> redirOut.target == $past(instrPc) + 32'h0000_0002
      + {{24{$past(instrWord[6])}}, $past(instrWord[6:0]), 1'b0})
    else $error("branch target wrong");
  short_reg_a: assert property ((opSel == c16bj_pkg::OP_BEQZ
    || opSel == c16bj_pkg::OP_BNEZ)
    |-> srcRegIdx inside {5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h10, 5'h11}
      && (shortSrc > 3'h1 || srcRegIdx == {4'h8, shortSrc[0]}))
    else $error("short register map wrong");
  link_write_a: assert property (issueOk && opSel == c16bj_pkg::OP_JALR
    |=> wbOut.en && wbOut.addr == 5'h1F && wbOut.data == $past(instrPc) + 32'h0000_0002)
    else $error("link write wrong");
  jump_bit0_a: assert property (redirOut.valid && !redirOut.modeBit
    |-> redirOut.target[0] == 1'b0 && (HAS_WORD_ISA || redirOut.addrErr))
    else $error("jump bit 0 handling wrong");
  stack_add_a: assert property (issueOk && opSel == c16bj_pkg::OP_JRSP
    |=> stackWbOut.en && stackWbOut.addr == 5'h1D && irqHoldOut
      && stackWbOut.data == $past(stackRegData) + {25'h0, $past(instrWord[9:5]), 2'h0})
    else $error("stack adjust wrong");
  slot_drop_a: assert property (redirOut.valid || brkExcOut
    |=> !redirOut.valid && !brkExcOut && !wbOut.en && !stackWbOut.en)
    else $error("follower of transfer executed");
  brk_trap_a: assert property (issueOk && opSel == c16bj_pkg::OP_BREAK
    |=> brkExcOut && !redirOut.valid && !wbOut.en)
    else $error("breakpoint not trapped");

  cover property (issueOk && opSel == c16bj_pkg::OP_BEQZ && takeBranch);
  cover property (issueOk && opSel == c16bj_pkg::OP_JRSP);
  cover property (issueOk && opSel == c16bj_pkg::OP_JALR ##2 issueOk && opSel == c16bj_pkg::OP_JR);
  cover property (redirOut.valid && redirOut.addrErr);
endmodule

// file: hdl/c16bj_jump_target.sv
/*
  register jump target shaping: mode bit, bit-0 clear and fetch error flag.
  purely combinational; the caller registers the results.
*/
`timescale 1ns/1ps
module c16bj_jump_target #(
  parameter bit HAS_WORD_ISA = 1'b0 // core also runs the 32-bit-only set
) (
  // jump source
  input wire logic [31:0] srcValue,
  // shaped target
  output logic [31:0] target,
  output logic modeBit,
  output logic addrErr
);
  // ==========================================
  // bit 0 always selects mode and is cleared from the address
  always_comb
  begin
    target = {srcValue[31:1], 1'b0};
    modeBit = srcValue[0];
    if (HAS_WORD_ISA)
    begin
      // word mode needs 4-byte alignment; bit 1 is the only leftover
      addrErr = ~srcValue[0] & srcValue[1];
    end
    else
    begin
      // word mode unsupported here, so it can only fault at fetch
      addrErr = ~srcValue[0];
    end
  end
endmodule

// file: hdl/c16bj_map.svh
/*
  constants of the compact branch and jump decoder: opcodes, field positions,
  fixed register numbers and reset values. assumes bit 15 is the instruction msb.
*/
// Operation
// - decode branch_if_zero_short, major 100011
// - decode branch_if_nonzero_short, major 101011
// - offset shifted one, added to pc+2
// - branch taken on zero / nonzero register
// - taken branch drops the following instruction
// - 3-bit specifier reaches registers 2-7,16,17
// - any instruction may follow branch or jump
// - breakpoint_short raises breakpoint exception at once
// - breakpoint code never delivered in registers
// - decode jump_link_register_short, minor 01011
// - link register 31 gets pc plus 2
// - single-set core: bit0 zero means address error
// - dual-set core: mode from bit0, word alignment
// - register jump drops the following instruction
// - jump_return_adjust_stack jumps through register 31
// - stack register 29 += zero-extended imm<<2
// - stack update wraps, never overflow trap
// - interrupt hold-off choice is documented
// - decode jump_register_short, minor 00011
`ifndef C16BJ_MAP_SVH
`define C16BJ_MAP_SVH
// ==========================================
// major opcodes, bits 15..10
`define C16BJ_MAJ_LSB 10
`define C16BJ_MAJ_BEQZ 6'h23
`define C16BJ_MAJ_BNEZ 6'h2B
`define C16BJ_MAJ_POOLC 6'h11
// ==========================================
// minor codes of minor_pool_group_c
`define C16BJ_MIN_BREAK 6'h1B
`define C16BJ_MIN_JALR 5'h0B
`define C16BJ_MIN_JR 5'h03
`define C16BJ_MIN_JRSP 5'h13
// ==========================================
// field positions
`define C16BJ_SRC5_LSB 5
`define C16BJ_SRC3_LSB 7
`define C16BJ_OFF_MSB 6
// ==========================================
// fixed registers, link step, reset values
`define C16BJ_REG_LINK 5'h1F
`define C16BJ_REG_STACK 5'h1D
`define C16BJ_REG_LOW0 5'h10
`define C16BJ_REG_LOW1 5'h11
`define C16BJ_PC_STEP 32'h0000_0002
`define C16BJ_RST_WORD 32'h0000_0000
`endif

// file: hdl/c16bj_pkg.sv
/*
  types shared by the decoder files: operation enum and output carriers.
  assumes the constants header is included alongside.
*/
package c16bj_pkg;
  // ==========================================
  // decoded operation
  typedef enum logic [2:0] {
    OP_NONE, OP_BEQZ, OP_BNEZ, OP_BREAK, OP_JALR, OP_JRSP, OP_JR
  } c16bj_op_e;
  // fetch redirect toward the fetch unit
  typedef struct packed {
    logic valid;        // one-cycle redirect pulse
    logic [31:0] target; // fetch address, bit 0 cleared for jumps
    logic modeBit;      // instruction_set_mode_bit for the target
    logic addrErr;      // fetch of target must raise address error
  } c16bj_redir_s;
  // register write-back
  typedef struct packed {
    logic en;
    logic [4:0] addr;
    logic [31:0] data;
  } c16bj_wb_s;
endpackage
